/* File: verilog/smco_pkg.sv */
// ============================================================
// Shared constants for the serial modem control outputs block.
// ============================================================
package smco_pkg;

	// Width of each port's modem line control register.
	localparam int unsigned MCR_W = 8;

	// Field positions inside the modem line control register.
	localparam int unsigned MCR_DTR_BIT  = 0;  // Terminal-ready request.
	localparam int unsigned MCR_RTS_BIT  = 1;  // Send request.
	localparam int unsigned MCR_LOOP_BIT = 4;  // Loopback mode.

	// Value of each modem line control register after reset.
	localparam logic [MCR_W-1:0] MCR_RST = 8'h00;

	// Width and values of the configuration index port base.
	localparam int unsigned BASE_W = 12;
	localparam logic [BASE_W-1:0] BASE_STRAP_LOW  = 12'h3F0;  // Strap sampled low.
	localparam logic [BASE_W-1:0] BASE_STRAP_HIGH = 12'h370;  // Strap sampled high.

	// Pin and strap capture levels after reset.
	localparam logic PIN_INACTIVE_RST = 1'h1;  // Handshake outputs high.
	localparam logic SER_IDLE_RST     = 1'h1;  // Serial lines idle high (mark).
	localparam logic STRAP_RST        = 1'h0;  // Strap before it is captured.
	localparam logic PENDING_RST      = 1'h1;  // Strap capture still owed.

	// Number of pin inputs that pass the synchroniser.
	localparam int unsigned SYNC_N = 3;
	localparam int unsigned SYNC_RX1   = 0;
	localparam int unsigned SYNC_RX2   = 1;
	localparam int unsigned SYNC_STRAP = 2;

endpackage

/* File: verilog/smco_pin_sync.sv */
`timescale 1ns/1ps
// ============================================================
// Three-stage pin synchroniser with agreement filter.
// ============================================================
// The filtered output changes only once the second and third stages agree,
// so a single-cycle glitch that survives the first stage never reaches logic.
// Stages carry no reset: they keep sampling while the block sits in reset,
// which is what lets the strap be ready at the release.
module smco_pin_sync (
	input  wire logic                        mclk,
	input  wire logic                        ce,
	input  wire logic [smco_pkg::SYNC_N-1:0] pin_in,
	output logic      [smco_pkg::SYNC_N-1:0] pin_q
);

	// ============================================================
	// State.
	// ============================================================
	typedef struct packed {
		logic [smco_pkg::SYNC_N-1:0] s1;  // First stage, read only by s2.
		logic [smco_pkg::SYNC_N-1:0] s2;  // Second stage.
		logic [smco_pkg::SYNC_N-1:0] s3;  // Third stage.
		logic [smco_pkg::SYNC_N-1:0] q;   // Filtered level.
	} smco_sync_s;

	smco_sync_s                       st_ff;   // Registered state.
	smco_sync_s                       nxt_st;  // Next state.
	wire logic [smco_pkg::SYNC_N-1:0] lane_q;  // Filtered level of each lane for the next edge.

	// ============================================================
	// Agreement filter, one generate lane per pin.
	// ============================================================
	// One lane per pin keeps the filter identical for all of them, while the
	// state itself is still filled by a single process below.
	genvar gi;
	generate
		for (gi = 0; gi < smco_pkg::SYNC_N; gi++) begin : g_lane
			// A change counts only when the two settled stages agree.
			assign lane_q[gi] = (st_ff.s2[gi] == st_ff.s3[gi]) ? st_ff.s3[gi] : st_ff.q[gi];
		end
	endgenerate

	// ============================================================
	// Next state: shift every stage by one.
	// ============================================================
	always_comb begin
		nxt_st.s1 = pin_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.q  = lane_q;
	end

	// ============================================================
	// Registers, frozen while the clock enable is low.
	// ============================================================
	always_ff @(posedge mclk) begin
		if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign pin_q = st_ff.q;

endmodule

/* File: verilog/smco_top.sv */
`timescale 1ns/1ps
// Function
// - Send request pin follows control bit one.
// - Reset drives port one send request pin high and releases port two's for the strap.
// - Loopback forces send request pin inactive.
// - Terminal-ready pin follows control bit zero.
// - Reset drives terminal-ready pins high.
// - Loopback forces terminal-ready pin inactive.
// - Port two send pin strap picks base.
// - Port two pins double as infrared.
module smco_top (
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	input  wire logic                       ce,
	input  wire logic                       port1_mcr_wr,
	input  wire logic [smco_pkg::MCR_W-1:0] port1_mcr_wdata,
	output logic      [smco_pkg::MCR_W-1:0] port1_mcr_rdata,
	input  wire logic                       port2_mcr_wr,
	input  wire logic [smco_pkg::MCR_W-1:0] port2_mcr_wdata,
	output logic      [smco_pkg::MCR_W-1:0] port2_mcr_rdata,
	input  wire logic                       port1_uart_tx,
	output logic                            port1_uart_rx,
	input  wire logic                       port2_uart_tx,
	output logic                            port2_uart_rx,
	input  wire logic                       ir_mode,
	input  wire logic                       ir_tx,
	output logic                            ir_rx,
	output logic                            port1_serial_tx,
	input  wire logic                       port1_serial_rx,
	output logic                            port2_serial_ir_tx,
	input  wire logic                       port2_serial_ir_rx,
	output logic                            port1_send_request_out_n,
	output logic                            port1_terminal_ready_out_n,
	output logic                            port2_send_request_out_n,
	output logic                            port2_send_request_oe_n,
	input  wire logic                       port2_send_request_in,
	output logic                            port2_terminal_ready_out_n,
	output logic                            config_base_strap,
	output logic                            strap_valid,
	output logic      [smco_pkg::BASE_W-1:0] config_index_base
);

	// ============================================================
	// Decoding shared by both ports.
	// ============================================================
	// Send request pin level: active low, held high in loopback.
	function automatic logic rts_level(input logic [smco_pkg::MCR_W-1:0] modem_line_control_reg);
		rts_level = ~modem_line_control_reg[smco_pkg::MCR_RTS_BIT] | modem_line_control_reg[smco_pkg::MCR_LOOP_BIT];
	endfunction

	// Terminal-ready pin level: active low, held high in loopback.
	function automatic logic dtr_level(input logic [smco_pkg::MCR_W-1:0] modem_line_control_reg);
		dtr_level = ~modem_line_control_reg[smco_pkg::MCR_DTR_BIT] | modem_line_control_reg[smco_pkg::MCR_LOOP_BIT];
	endfunction

	// ============================================================
	// State.
	// ============================================================
	typedef struct packed {
		logic [smco_pkg::MCR_W-1:0]  mcr1;      // Port one modem line control register.
		logic [smco_pkg::MCR_W-1:0]  mcr2;      // Port two modem line control register.
		logic                        rts1_n;    // Port one send request pin.
		logic                        dtr1_n;    // Port one terminal-ready pin.
		logic                        rts2_n;    // Port two send request pin.
		logic                        dtr2_n;    // Port two terminal-ready pin.
		logic                        rts2_oe_n; // Port two send request drive enable.
		logic                        pending;   // Strap not yet captured.
		logic                        strap;     // Captured strap level.
		logic [smco_pkg::BASE_W-1:0] base;      // Configuration index base.
		logic                        tx1;       // Port one line out.
		logic                        tx2;       // Port two line out.
		logic                        urx1;      // Port one receive to the core.
		logic                        urx2;      // Port two receive to the core.
		logic                        irx;       // Infrared receive to the core.
	} smco_top_s;

	// Values after reset, built from package constants.
	localparam smco_top_s ST_RST = '{
		mcr1:      smco_pkg::MCR_RST,
		mcr2:      smco_pkg::MCR_RST,
		rts1_n:    smco_pkg::PIN_INACTIVE_RST,
		dtr1_n:    smco_pkg::PIN_INACTIVE_RST,
		rts2_n:    smco_pkg::PIN_INACTIVE_RST,
		dtr2_n:    smco_pkg::PIN_INACTIVE_RST,
		rts2_oe_n: smco_pkg::PIN_INACTIVE_RST,
		pending:   smco_pkg::PENDING_RST,
		strap:     smco_pkg::STRAP_RST,
		base:      smco_pkg::BASE_STRAP_LOW,
		tx1:       smco_pkg::SER_IDLE_RST,
		tx2:       smco_pkg::SER_IDLE_RST,
		urx1:      smco_pkg::SER_IDLE_RST,
		urx2:      smco_pkg::SER_IDLE_RST,
		irx:       smco_pkg::SER_IDLE_RST
	};

	smco_top_s                   st_ff;   // Registered state.
	smco_top_s                   nxt_st;  // Next state.
	logic [smco_pkg::SYNC_N-1:0] pin_raw; // Pins before synchronising.
	logic [smco_pkg::SYNC_N-1:0] pin_q;   // Pins after synchronising.

	// ============================================================
	// Pin synchroniser for receive lines and the strap.
	// ============================================================
	always_comb begin
		pin_raw = '0;
		pin_raw[smco_pkg::SYNC_RX1]   = port1_serial_rx;
		pin_raw[smco_pkg::SYNC_RX2]   = port2_serial_ir_rx;
		pin_raw[smco_pkg::SYNC_STRAP] = port2_send_request_in;
	end

	smco_pin_sync u_sync (
		.mclk   (mclk),
		.ce     (ce),
		.pin_in (pin_raw),
		.pin_q  (pin_q)
	);

	// ============================================================
	// Next-state logic.
	// ============================================================
	always_comb begin
		nxt_st = st_ff;
		// Software writes to the control registers.
		if (port1_mcr_wr) begin
			nxt_st.mcr1 = port1_mcr_wdata;
		end
		if (port2_mcr_wr) begin
			nxt_st.mcr2 = port2_mcr_wdata;
		end
		// Pins are computed from the new register value so they move on the same edge.
		nxt_st.rts1_n = rts_level(nxt_st.mcr1);
		nxt_st.rts2_n = rts_level(nxt_st.mcr2);
		nxt_st.dtr1_n = dtr_level(nxt_st.mcr1);
		nxt_st.dtr2_n = dtr_level(nxt_st.mcr2);
		// The strap is taken on the first enabled edge after release; the pin is
		// not driven until then, so the board pull alone sets its level.
		if (st_ff.pending) begin
			nxt_st.pending   = 1'h0;
			nxt_st.rts2_oe_n = 1'h0;
			nxt_st.strap     = pin_q[smco_pkg::SYNC_STRAP];
			if (pin_q[smco_pkg::SYNC_STRAP]) begin
				nxt_st.base = smco_pkg::BASE_STRAP_HIGH;
			end else begin
				nxt_st.base = smco_pkg::BASE_STRAP_LOW;
			end
		end
		// Port one carries only serial data.
		nxt_st.tx1  = port1_uart_tx;
		nxt_st.urx1 = pin_q[smco_pkg::SYNC_RX1];
		// Port two lines serve either the serial core or the infrared path; the
		// unselected receiver sees idle so it never decodes the other's traffic.
		if (ir_mode) begin
			nxt_st.tx2  = ir_tx;
			nxt_st.irx  = pin_q[smco_pkg::SYNC_RX2];
			nxt_st.urx2 = smco_pkg::SER_IDLE_RST;
		end else begin
			nxt_st.tx2  = port2_uart_tx;
			nxt_st.urx2 = pin_q[smco_pkg::SYNC_RX2];
			nxt_st.irx  = smco_pkg::SER_IDLE_RST;
		end
	end

	// ============================================================
	// Registers: synchronous reset wins over the clock enable.
	// ============================================================
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st_ff <= ST_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// ============================================================
	// Outputs, all from flip-flops.
	// ============================================================
	assign port1_mcr_rdata            = st_ff.mcr1;
	assign port2_mcr_rdata            = st_ff.mcr2;
	assign port1_send_request_out_n   = st_ff.rts1_n;
	assign port1_terminal_ready_out_n = st_ff.dtr1_n;
	assign port2_send_request_out_n   = st_ff.rts2_n;
	assign port2_send_request_oe_n    = st_ff.rts2_oe_n;
	assign port2_terminal_ready_out_n = st_ff.dtr2_n;
	assign config_base_strap          = st_ff.strap;
	assign strap_valid                = ~st_ff.pending;
	assign config_index_base          = st_ff.base;
	assign port1_serial_tx            = st_ff.tx1;
	assign port2_serial_ir_tx         = st_ff.tx2;
	assign port1_uart_rx              = st_ff.urx1;
	assign port2_uart_rx              = st_ff.urx2;
	assign ir_rx                      = st_ff.irx;

	// ============================================================
	// Assertions.
	// ============================================================
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	// A write on an enabled edge.
	sequence s_wr1;
		ce && port1_mcr_wr;
	endsequence

	sequence s_wr2;
		ce && port2_mcr_wr;
	endsequence

	property p_rts1_follow;
		s_wr1 |=> port1_send_request_out_n ==
			(~$past(port1_mcr_wdata[smco_pkg::MCR_RTS_BIT]) | $past(port1_mcr_wdata[smco_pkg::MCR_LOOP_BIT]));
	endproperty
	a_rts1_follow: assert property (p_rts1_follow) else $error("Port one send pin ignores write.");

	property p_rst_inactive;
		$rose(resetn) |-> port1_send_request_out_n && port2_send_request_out_n;
	endproperty
	a_rst_inactive: assert property (p_rst_inactive) else $error("Send pins not high after reset.");

	property p_loop_rts;
		port2_mcr_rdata[smco_pkg::MCR_LOOP_BIT] |-> port2_send_request_out_n;
	endproperty
	a_loop_rts: assert property (p_loop_rts) else $error("Send pin active in loopback.");

	property p_dtr2_follow;
		s_wr2 ##1 !port2_mcr_rdata[smco_pkg::MCR_LOOP_BIT] |->
			port2_terminal_ready_out_n == ~$past(port2_mcr_wdata[smco_pkg::MCR_DTR_BIT]);
	endproperty
	a_dtr2_follow: assert property (p_dtr2_follow) else $error("Port two terminal pin ignores write.");

	property p_rst_dtr;
		$rose(resetn) |-> port1_terminal_ready_out_n && port2_terminal_ready_out_n;
	endproperty
	a_rst_dtr: assert property (p_rst_dtr) else $error("Terminal pins not high after reset.");

	property p_loop_dtr;
		port1_mcr_rdata[smco_pkg::MCR_LOOP_BIT] |-> port1_terminal_ready_out_n;
	endproperty
	a_loop_dtr: assert property (p_loop_dtr) else $error("Terminal pin active in loopback.");

	sequence s_strap_take;
		ce && !strap_valid ##1 strap_valid;
	endsequence

	property p_strap_base;
		s_strap_take |-> config_index_base ==
			(config_base_strap ? smco_pkg::BASE_STRAP_HIGH : smco_pkg::BASE_STRAP_LOW)
			&& !port2_send_request_oe_n ##1 $stable(config_index_base);
	endproperty
	a_strap_base: assert property (p_strap_base) else $error("Base does not match strap.");

	property p_ir_tx;
		ce && ir_mode |=> port2_serial_ir_tx == $past(ir_tx) && port2_uart_rx;
	endproperty
	a_ir_tx: assert property (p_ir_tx) else $error("Infrared path not on port two.");

	// With the clock enable low the control registers, and so the pins, must not move.
	property p_ce_hold;
		!ce |=> $stable(port1_mcr_rdata) && $stable(port2_mcr_rdata);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("Control register moved while frozen.");

endmodule

/* File: tb/smco_line_model.sv */
`timescale 1ns/1ps
// ============================================================
// Board pull and far-end line drivers of the serial pins.
// ============================================================
// The send-request pin of port two is released while the block is in reset.
// The board pull then sets the level that the strap capture sees.
module smco_line_model (
	input  wire logic port2_send_request_out_n,
	input  wire logic port2_send_request_oe_n,
	input  wire logic strap_level,
	input  wire logic rx1_bit,
	input  wire logic rx2_bit,
	output logic      port2_send_request_in,
	output logic      port1_serial_rx,
	output logic      port2_serial_ir_rx
);
	// The pull wins only while the block does not drive the pin.
	assign port2_send_request_in = port2_send_request_oe_n ? strap_level : port2_send_request_out_n;
	// The far transmitters drive their data lines at all times, so no float is modelled.
	assign port1_serial_rx    = rx1_bit;
	assign port2_serial_ir_rx = rx2_bit;
endmodule

/* File: tb/smco_top_tb.sv */
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the modem control outputs.
// ============================================================
module smco_top_tb;
	logic mclk = 1'h0, resetn = 1'h0, ce = 1'h1;    // Clock, reset and enable.
	logic p1_wr = 1'h0, p2_wr = 1'h0;               // Control register strobes.
	logic [7:0] p1_wd = 8'h00, p2_wd = 8'h00, p1_rd, p2_rd;  // Control register data.
	logic p1_utx = 1'h1, p2_utx = 1'h1, ir_mode = 1'h0, ir_tx = 1'h1;  // Core side inputs.
	logic p1_urx, p2_urx, ir_rx, p1_stx, p2_stx, p1_srx, p2_srx;  // Data paths.
	logic p1_rts, p1_dtr, p2_rts, p2_oe, p2_pin, p2_dtr;  // Handshake pins.
	logic strap, strap_valid;                       // Captured strap.
	logic [11:0] base;                              // Index port base.
	logic strap_level = 1'h1, rx1_bit = 1'h1, rx2_bit = 1'h1;  // Far side levels.
	logic [31:0] seed = 32'hBFAB;                   // Random source state.
	int mismatches = 0, check_count = 0, cycles = 0;
	logic [7:0] fixed [5] = '{8'h03, 8'h13, 8'h02, 8'h11, 8'h00};  // Corner values.

	// 25 MHz clock.
	always #20 mclk = ~mclk;

	smco_top uut (.mclk(mclk), .resetn(resetn), .ce(ce), .port1_mcr_wr(p1_wr), .port1_mcr_wdata(p1_wd),
		.port1_mcr_rdata(p1_rd), .port2_mcr_wr(p2_wr), .port2_mcr_wdata(p2_wd), .port2_mcr_rdata(p2_rd),
		.port1_uart_tx(p1_utx), .port1_uart_rx(p1_urx), .port2_uart_tx(p2_utx), .port2_uart_rx(p2_urx),
		.ir_mode(ir_mode), .ir_tx(ir_tx), .ir_rx(ir_rx), .port1_serial_tx(p1_stx),
		.port1_serial_rx(p1_srx), .port2_serial_ir_tx(p2_stx), .port2_serial_ir_rx(p2_srx),
		.port1_send_request_out_n(p1_rts), .port1_terminal_ready_out_n(p1_dtr),
		.port2_send_request_out_n(p2_rts), .port2_send_request_oe_n(p2_oe),
		.port2_send_request_in(p2_pin), .port2_terminal_ready_out_n(p2_dtr),
		.config_base_strap(strap), .strap_valid(strap_valid), .config_index_base(base));

	smco_line_model line (.port2_send_request_out_n(p2_rts), .port2_send_request_oe_n(p2_oe),
		.strap_level(strap_level), .rx1_bit(rx1_bit), .rx2_bit(rx2_bit), .port2_send_request_in(p2_pin),
		.port1_serial_rx(p1_srx), .port2_serial_ir_rx(p2_srx));

	// Next value of the random source.
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Compare one value and count it.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Print the counts and the verdict, then stop.
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Reset with a given strap level, then watch the capture.
	task automatic do_reset(input logic lvl);
		int n;
		n = 0;
		@(posedge mclk);
		resetn <= 1'h0;
		strap_level <= lvl;
		repeat (12) @(posedge mclk);
		#1;
		check({14'h0, p1_rts, p2_rts}, 16'h3);
		check({14'h0, p1_dtr, p2_dtr}, 16'h3);
		check({p1_rd, p2_rd}, 16'h0);
		@(posedge mclk);
		resetn <= 1'h1;
		while (strap_valid !== 1'h1 && n < 8) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check(16'(n), 16'h1);
		check({1'h0, strap_valid, p2_oe, strap, base}, {1'h0, 1'h1, 1'h0, lvl, lvl ? 12'h370 : 12'h3F0});
		strap_level <= ~lvl;
		repeat (8) @(posedge mclk);
		#1;
		check({3'h0, strap, base}, {3'h0, lvl, lvl ? 12'h370 : 12'h3F0});
		$display("test reset strap %0d done", lvl);
	endtask

	// Write one control register and compare pins with the model.
	task automatic wr_mcr(input int port, input logic [7:0] v);
		int iv, loop_on, rts_n, dtr_n;
		iv = v;
		loop_on = (iv >> 4) & 1;
		rts_n = loop_on ? 1 : 1 - ((iv >> 1) & 1);
		dtr_n = loop_on ? 1 : 1 - (iv & 1);
		@(posedge mclk);
		if (port == 1) begin
			p1_wr <= 1'h1;
			p1_wd <= v;
		end else begin
			p2_wr <= 1'h1;
			p2_wd <= v;
		end
		@(posedge mclk);
		p1_wr <= 1'h0;
		p2_wr <= 1'h0;
		#1;
		check(port == 1 ? {8'h0, p1_rd} : {8'h0, p2_rd}, {8'h0, v});
		check({15'h0, port == 1 ? p1_rts : p2_rts}, 16'(rts_n));
		check({15'h0, port == 1 ? p1_dtr : p2_dtr}, 16'(dtr_n));
		if (port == 2) check({15'h0, p2_pin}, 16'(rts_n));
	endtask

	// Cut a hung run short.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	// Main sequence.
	initial begin
		do_reset(1'h1);
		foreach (fixed[i]) begin
			wr_mcr(1, fixed[i]);
			wr_mcr(2, fixed[i]);
		end
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			wr_mcr(seed[0] ? 2 : 1, seed[15:8]);
		end
		$display("test control writes done");
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			@(posedge mclk);
			{p1_utx, p2_utx, ir_tx, ir_mode} <= seed[3:0];
			{rx1_bit, rx2_bit} <= seed[5:4];
			@(posedge mclk);
			#1;
			check({14'h0, p1_stx, p2_stx}, {14'h0, seed[3], seed[0] ? seed[1] : seed[2]});
			repeat (7) @(posedge mclk);
			#1;
			check({13'h0, p1_urx, p2_urx, ir_rx}, {13'h0, seed[5], seed[0] ? 1'h1 : seed[4], seed[0] ? seed[4] : 1'h1});
		end
		$display("test data paths done");
		wr_mcr(1, 8'h03);
		// Clock enable low: a held write strobe must be ignored and the pins stay put.
		@(posedge mclk);
		ce <= 1'h0;
		p1_wr <= 1'h1;
		p1_wd <= 8'h00;
		repeat (3) @(posedge mclk);
		#1;
		check({p1_rd, 6'h0, p1_rts, p1_dtr}, 16'h0300);
		@(posedge mclk);
		ce <= 1'h1;
		p1_wr <= 1'h0;
		$display("test clock enable done");
		wr_mcr(2, 8'h03);
		do_reset(1'h0);
		wr_mcr(2, 8'h02);
		print_verdict();
	end
endmodule
